// *** design/sync_burst_sram_control.sv ***
// What this block does
// (R01) Flow select low bypasses output register
// (R02) Deselect depth low picks dual deselect
// (R03) Sleep high puts device in standby
// (R04) Parity enable low activates parity lanes
// (R05) Burst counter linear or interleaved, wraps
// (R06) Read when no write decoded; all drive
// (R07) Byte writes per enable; global writes all
// (R08) Data lanes stay off during writes
// (R09) Lanes c and d only when wide
// (R10) Chip off plus controller strobe deselects
// (R11) Processor strobe with chip on reads
// (R12) Controller strobe loads; write per decode
// (R13) Both strobes high, step low advances
// (R14) Step high holds the burst address
// (R15) Output enable high forces drivers off
// (R16) Host may tie strobes for single cycles
// (R17) Host may tie strobes for simple bursts
// (R18) Low address bits preset burst counter
// (R19) Burst step is active low
// (R20) Pipeline one clock later; single deselect sooner
// (R21) Writes captured at edge, counter address
`include "sync_burst_sram_defs.svh"

module sync_burst_sram_control
    import sync_burst_sram_pkg::*;
#(
    parameter int ADDR_W = `SBS_ADDR_W,
    parameter bit WIDE   = 1'b1
) (
    input  wire logic                                 clock_i,              // Core clock
    input  wire logic                                 arst_n_i,             // Async reset, low
    input  wire logic [ADDR_W-1:0]                    addr_i,               // Address pins
    input  wire logic [`SBS_LANES*`SBS_LANE_W-1:0]    data_in_i,            // Data pins, input side
    output logic      [`SBS_LANES*`SBS_LANE_W-1:0]    data_out_o,           // Data pins, output side
    output logic      [`SBS_LANES*`SBS_LANE_W-1:0]    data_oe_o,            // Data pins, enable high
    input  wire logic                                 chip_enable_n_i,      // Chip enable, low
    input  wire logic                                 proc_addr_strobe_n_i, // Processor strobe, low
    input  wire logic                                 ctrl_addr_strobe_n_i, // Controller strobe, low
    input  wire logic                                 burst_step_n_i,       // Burst advance, low
    input  wire logic                                 global_write_n_i,     // Write all bytes, low
    input  wire logic                                 byte_write_n_i,       // Byte write, low
    input  wire logic [`SBS_LANES-1:0]                byte_enable_n_i,      // Lane enables a..d, low
    input  wire logic                                 output_enable_n_i,    // Output enable, low
    input  wire logic                                 flow_select_n_i,      // Low flow-through
    input  wire logic                                 deselect_depth_sel_i, // Low dual deselect
    input  wire logic                                 sleep_req_i,          // High standby
    input  wire logic                                 parity_lane_en_n_i,   // Low parity lanes on
    input  wire logic                                 burst_order_sel_n_i,  // Low linear order
    output logic                                      standby_o             // Device in standby
);

    localparam int LANES  = `SBS_LANES;
    localparam int LANE_W = `SBS_LANE_W;
    localparam int DATA_W = LANES * LANE_W;
    localparam int BW     = `SBS_BURST_W;
    localparam logic [LANES-1:0] LANE_MASK = WIDE ? `SBS_WIDE_LANES : `SBS_NARROW_LANES;

    mode_type                mode_raw;
    mode_type                mode_meta_q;
    mode_type                mode_q;
    cycle_kind_type          cyc;
    out_event_type           ev_now;
    out_event_type           ev1_q;
    out_event_type           ev2_q;
    logic                    desel_cmd;
    logic                    begin_p;
    logic                    begin_c;
    logic                    cont_cmd;
    logic                    load;
    logic                    advance;
    logic [LANES-1:0]        lane_we;
    logic                    wr_req;
    logic [LANES-1:0]        mem_we;
    logic [ADDR_W-1:0]       mem_addr;
    logic [ADDR_W-1:0]       addr_hi_q;
    logic [BW-1:0]           low_addr;
    logic [DATA_W-1:0]       wdata;
    logic [DATA_W-1:0]       rdata;
    logic [DATA_W-1:0]       stage_q;
    logic [DATA_W-1:0]       lane_keep;
    logic [DATA_W-1:0]       oe_d;
    logic                    drive_d;
    logic                    drive_q;

    // Mode pins and output enable are asynchronous; the first flop feeds only the second
    assign mode_raw = '{flow:       ~flow_select_n_i,
                        dcd:        ~deselect_depth_sel_i,
                        sleep:      sleep_req_i,
                        parity:     ~parity_lane_en_n_i,
                        interleave: burst_order_sel_n_i,
                        out_off:    output_enable_n_i};

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_meta_q <= `SBS_MODE_RESET;
            mode_q      <= `SBS_MODE_RESET;
        end else begin
            mode_meta_q <= mode_raw;
            mode_q      <= mode_meta_q;
        end
    end

    // Write decode
    always_comb begin
        lane_we = '0;
        if (!global_write_n_i) begin
            lane_we = LANE_MASK; // R07 R09
        end else if (!byte_write_n_i) begin
            lane_we = ~byte_enable_n_i & LANE_MASK; // R07 R09
        end
        wr_req = |lane_we; // R06
    end

    // Command decode
    assign desel_cmd = chip_enable_n_i & ~ctrl_addr_strobe_n_i; // R10
    assign begin_p   = ~chip_enable_n_i & ~proc_addr_strobe_n_i; // R11
    assign begin_c   = ~chip_enable_n_i & proc_addr_strobe_n_i & ~ctrl_addr_strobe_n_i; // R12
    assign cont_cmd  = ~desel_cmd & ~begin_p & ~begin_c; // R13 R14
    assign load      = ~mode_q.sleep & (begin_p | begin_c); // R18
    assign advance   = ~mode_q.sleep & cont_cmd & ~burst_step_n_i; // R13 R19

    always_comb begin
        if (mode_q.sleep) begin
            cyc = CYC_IDLE; // R03
        end else if (desel_cmd) begin
            cyc = CYC_DESEL; // R10
        end else if (begin_p) begin
            cyc = CYC_READ; // R11
        end else if (wr_req) begin
            cyc = CYC_WRITE; // R12 R13 R14
        end else begin
            cyc = CYC_READ; // R06
        end
    end

    burst_addr_counter u_counter (
        .clock_i      (clock_i),
        .arst_n_i     (arst_n_i),
        .load_i       (load),
        .load_val_i   (addr_i[BW-1:0]),
        .advance_i    (advance),
        .interleave_i (mode_q.interleave),
        .cur_addr_o   (low_addr)
    );

    // Upper address bits are held for the whole burst
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            addr_hi_q <= '0;
        end else if (load) begin
            addr_hi_q <= addr_i;
        end
    end

    assign mem_addr = {(load ? addr_i[ADDR_W-1:BW] : addr_hi_q[ADDR_W-1:BW]), low_addr}; // R14 R21

    always_comb begin
        case (cyc)
            CYC_WRITE: mem_we = lane_we; // R21
            CYC_IDLE:  mem_we = '0;
            CYC_DESEL: mem_we = '0;
            CYC_READ:  mem_we = '0;
            default:   mem_we = '0;
        endcase
    end

    // Parity bits store zero while the parity lanes are off
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        assign wdata[l*LANE_W +: LANE_W-1]   = data_in_i[l*LANE_W +: LANE_W-1];
        assign wdata[l*LANE_W + LANE_W-1]    = data_in_i[l*LANE_W + LANE_W-1] & mode_q.parity; // R04
        assign oe_d[l*LANE_W +: LANE_W-1]    = {(LANE_W-1){drive_d & ~mode_q.out_off & LANE_MASK[l]}}; // R06 R09 R15
        assign oe_d[l*LANE_W + LANE_W-1]     = drive_d & ~mode_q.out_off & LANE_MASK[l] & mode_q.parity; // R04
        assign lane_keep[l*LANE_W +: LANE_W] = {LANE_W{LANE_MASK[l]}}; // R09
    end

    sram_array #(
        .ADDR_W (ADDR_W),
        .LANES  (LANES),
        .LANE_W (LANE_W)
    ) u_array (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .addr_i   (mem_addr),
        .we_i     (mem_we),
        .wdata_i  (wdata),
        .rdata_o  (rdata)
    );

    assign ev_now = '{read: cyc == CYC_READ, desel: cyc == CYC_DESEL};

    // A write drops any read still in flight so it cannot drive into the write
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ev1_q <= '0;
            ev2_q <= '0;
        end else begin
            ev1_q <= ev_now;
            ev2_q <= (cyc == CYC_WRITE) ? '0 : ev1_q; // R08
        end
    end

    // Oldest stage first; a newer command overrides an older one
    always_comb begin
        drive_d = drive_q;
        if (!mode_q.flow && ev2_q.read) begin
            drive_d = 1'b1; // R01 R20
        end
        if (!mode_q.flow && mode_q.dcd && ev2_q.desel) begin
            drive_d = 1'b0; // R02 R20
        end
        if (mode_q.flow && ev1_q.read) begin
            drive_d = 1'b1; // R01 R20
        end
        if ((mode_q.flow == mode_q.dcd) && ev1_q.desel) begin
            drive_d = 1'b0; // R02 R20
        end
        if (mode_q.flow && !mode_q.dcd && ev_now.desel) begin
            drive_d = 1'b0; // R02 R20
        end
        if (cyc == CYC_WRITE || mode_q.sleep) begin
            drive_d = 1'b0; // R03 R08
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            drive_q   <= 1'b0;
            data_oe_o <= '0;
            standby_o <= 1'b0;
        end else begin
            drive_q   <= drive_d;
            data_oe_o <= oe_d; // R15
            standby_o <= mode_q.sleep; // R03
        end
    end

    // Output register stage is loaded in every mode; only pipeline mode reads it
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage_q    <= '0;
            data_out_o <= '0;
        end else begin
            // Absent lanes read as zero, never as unwritten array words
            stage_q    <= rdata & lane_keep; // R09
            data_out_o <= mode_q.flow ? (rdata & lane_keep) : stage_q; // R01 R20
        end
    end

    chk_write_hiz: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R08
        cyc == CYC_WRITE |=> data_oe_o == '0)
        else $error("data lanes driven in a write cycle");

    chk_out_off: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R15
        mode_q.out_off |=> data_oe_o == '0)
        else $error("output enable high did not stop drivers");

    chk_flow_data: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R01
        (cyc == CYC_READ && mode_q.flow && $stable(mode_q)) |=> ##1 data_out_o == ($past(rdata) & lane_keep))
        else $error("flow-through read data late or wrong");

    chk_pipe_data: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R20
        (cyc == CYC_READ && !mode_q.flow && $stable(mode_q)) |=> ##2 data_out_o == ($past(rdata, 2) & lane_keep))
        else $error("pipeline read data not one clock later");

    chk_pipe_drive: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R20
        (cyc == CYC_READ && !mode_q.flow && !mode_q.out_off) ##1 (cyc == CYC_READ && !mode_q.out_off)
        ##1 (cyc == CYC_READ && !mode_q.out_off) |=> data_oe_o[LANE_W-2:0] == {(LANE_W-1){1'b1}})
        else $error("pipeline read did not drive");

    chk_scd_flow_off: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R02
        (cyc == CYC_DESEL && mode_q.flow && !mode_q.dcd) |=> data_oe_o == '0)
        else $error("single deselect did not turn off at once");

    chk_global_write: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R07
        (cyc == CYC_WRITE && !global_write_n_i) |-> mem_we == LANE_MASK)
        else $error("global write missed a lane");

    chk_byte_write: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R07
        (cyc == CYC_WRITE && global_write_n_i) |-> mem_we == (~byte_enable_n_i & LANE_MASK))
        else $error("byte write lanes wrong");

    chk_narrow_lanes: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R09
        (mem_we & ~LANE_MASK) == '0 && (data_oe_o[DATA_W-1:2*LANE_W] & {(DATA_W-2*LANE_W){~WIDE}}) == '0)
        else $error("absent lanes used");

    chk_parity_off: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R04
        (!mode_q.parity && $stable(mode_q)) |=> data_oe_o[LANE_W-1] == 1'b0)
        else $error("parity lane driven while disabled");

    chk_deselect: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R10
        (!mode_q.sleep && chip_enable_n_i && !ctrl_addr_strobe_n_i) |-> cyc == CYC_DESEL && mem_we == '0)
        else $error("deselect not decoded");

    chk_proc_read: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R11
        (!mode_q.sleep && !chip_enable_n_i && !proc_addr_strobe_n_i)
        |-> cyc == CYC_READ && mem_addr == addr_i)
        else $error("processor strobe did not start a read");

    chk_ctrl_begin: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R12
        (!mode_q.sleep && begin_c) |-> mem_addr == addr_i && (cyc == CYC_WRITE) == wr_req)
        else $error("controller strobe cycle wrong");

    chk_continue: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R13
        (!mode_q.sleep && cont_cmd) |-> (cyc == CYC_WRITE) == wr_req && (cyc != CYC_DESEL))
        else $error("continue cycle kind wrong");

    chk_hold_addr: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R14
        (!mode_q.sleep && cont_cmd && burst_step_n_i && $stable(mode_q.interleave)) ##1
        (!mode_q.sleep && cont_cmd && burst_step_n_i && $stable(mode_q.interleave)) |-> mem_addr == $past(mem_addr))
        else $error("suspended burst moved its address");

    chk_sleep_quiet: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R03
        mode_q.sleep |-> mem_we == '0 ##1 (data_oe_o == '0 && standby_o))
        else $error("standby still active");

endmodule

// *** design/sync_burst_sram_defs.svh ***
`ifndef SYNC_BURST_SRAM_DEFS_SVH
`define SYNC_BURST_SRAM_DEFS_SVH

`define SBS_LANES         4
`define SBS_LANE_W        9
`define SBS_ADDR_W        18
`define SBS_BURST_W       2
`define SBS_WIDE_LANES    4'hF
`define SBS_NARROW_LANES  4'h3
`define SBS_CLK_PERIOD_NS 40
// Reset value of the synchronised mode pins: pipeline, single deselect,
// active, parity off, interleaved, outputs off
`define SBS_MODE_RESET    6'h03

`endif

// *** design/sync_burst_sram_pkg.sv ***
`include "sync_burst_sram_defs.svh"

package sync_burst_sram_pkg;

    typedef enum logic [3:0] {
        CYC_IDLE  = 4'b0001,
        CYC_DESEL = 4'b0010,
        CYC_READ  = 4'b0100,
        CYC_WRITE = 4'b1000
    } cycle_kind_type;

    typedef struct packed {
        logic flow;
        logic dcd;
        logic sleep;
        logic parity;
        logic interleave;
        logic out_off;
    } mode_type;

    typedef struct packed {
        logic read;
        logic desel;
    } out_event_type;

endpackage

// *** design/burst_addr_counter.sv ***
`include "sync_burst_sram_defs.svh"

module burst_addr_counter (
    input  wire logic                    clock_i,      // Core clock
    input  wire logic                    arst_n_i,     // Async reset, low
    input  wire logic                    load_i,       // Burst begins
    input  wire logic [`SBS_BURST_W-1:0] load_val_i,   // External low address bits
    input  wire logic                    advance_i,    // Step to next address
    input  wire logic                    interleave_i, // 1 interleaved, 0 linear
    output logic      [`SBS_BURST_W-1:0] cur_addr_o    // Address used this cycle
);

    logic [`SBS_BURST_W-1:0] start_q;
    logic [`SBS_BURST_W-1:0] cnt_q;
    logic [`SBS_BURST_W-1:0] cnt_inc;

    function automatic logic [`SBS_BURST_W-1:0] seq_addr(input logic [`SBS_BURST_W-1:0] start,
                                                        input logic [`SBS_BURST_W-1:0] cnt,
                                                        input logic                    il);
        seq_addr = il ? (start ^ cnt) : (start + cnt); // R05
    endfunction

    assign cnt_inc = cnt_q + 2'h1;

    always_comb begin
        if (load_i) begin
            cur_addr_o = load_val_i; // R18
        end else if (advance_i) begin
            cur_addr_o = seq_addr(start_q, cnt_inc, interleave_i); // R19
        end else begin
            cur_addr_o = seq_addr(start_q, cnt_q, interleave_i);
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            start_q <= 2'h0;
            cnt_q   <= 2'h0;
        end else if (load_i) begin
            start_q <= load_val_i; // R18
            cnt_q   <= 2'h0;
        end else if (advance_i) begin
            // Two-bit count wraps by itself, back to the start address
            cnt_q <= cnt_inc; // R05
        end
    end

    chk_burst_wrap: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R05
        load_i ##1 (advance_i && !load_i) [*4] |-> cur_addr_o == $past(load_val_i, 4))
        else $error("burst address did not wrap to start");

    chk_linear_step: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R05
        (load_i && !interleave_i) ##1 (advance_i && !load_i && !interleave_i)
        |-> cur_addr_o == $past(load_val_i) + 2'h1)
        else $error("linear burst step wrong");

    chk_interleave_step: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R05
        (load_i && interleave_i) ##1 (advance_i && !load_i && interleave_i)
        |-> cur_addr_o == ($past(load_val_i) ^ 2'h1))
        else $error("interleaved burst step wrong");

    chk_step_held: assert property (@(posedge clock_i) disable iff (!arst_n_i) // R19
        (!load_i && !advance_i && $stable(interleave_i)) |=> (!load_i && !advance_i && $stable(interleave_i))
        |-> cur_addr_o == $past(cur_addr_o))
        else $error("burst address moved without advance");

endmodule

// *** design/sram_array.sv ***
module sram_array #(
    parameter int ADDR_W = 18,
    parameter int LANES  = 4,
    parameter int LANE_W = 9
) (
    input  wire logic                     clock_i,  // Core clock
    input  wire logic                     arst_n_i, // Async reset, low
    input  wire logic [ADDR_W-1:0]        addr_i,   // Word address
    input  wire logic [LANES-1:0]         we_i,     // Per-lane write strobe
    input  wire logic [LANES*LANE_W-1:0]  wdata_i,  // Write data
    output logic      [LANES*LANE_W-1:0]  rdata_o   // Registered read data
);

    logic [LANES*LANE_W-1:0] mem [2**ADDR_W];

    // Read returns the old word when the same edge writes it
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem[addr_i];
        end
    end

    // One process owns the array; a lane loop inside keeps byte writes apart
    always_ff @(posedge clock_i) begin
        for (int l = 0; l < LANES; l++) begin
            if (we_i[l]) begin
                mem[addr_i][l*LANE_W +: LANE_W] <= wdata_i[l*LANE_W +: LANE_W];
            end
        end
    end

endmodule

// *** tb/bus_host.sv ***
module bus_host
    import sync_burst_sram_pkg::*;
#(
    parameter int AW = 6
) (
    input  wire logic          clock_i,   // Core clock
    input  wire logic [35:0]   dev_out_i, // Device data
    input  wire logic [35:0]   dev_oe_i,  // Device drive enable
    output logic      [35:0]   pins_o,    // Resolved data pins
    output logic      [AW-1:0] addr_o,    // Address
    output logic      [5:0]    ctl_o,     // ce, proc_addr_strobe_n, ctrl_addr_strobe_n, adv, gw, bw; all low
    output logic      [3:0]    be_o       // Lane enables, low
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [35:0] drv_q;

    // Released pins toggle so stale data never reads back by luck
    assign pins_o = (dev_oe_i & dev_out_i) | (~dev_oe_i & drv_q);

    initial begin
        // Idle as deselect so no read touches unwritten words
        ctl_o  = 6'h37;
        be_o   = 4'hF;
        addr_o = '0;
        drv_q  = '0;
    end

    // One command per edge, held until the next edge
    task automatic cmd(input logic [5:0] c, input logic [3:0] be, input logic [AW-1:0] a, input logic [35:0] d);
        @(posedge clock_i);
        #1;
        ctl_o  = c;
        be_o   = be;
        addr_o = a;
        drv_q  = (!c[1] || !c[0]) ? d : ~drv_q;
    endtask
endmodule

// *** tb/sync_burst_sram_control_test.sv ***
module sync_burst_sram_control_test
    import sync_burst_sram_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end

    localparam logic [35:0] ALL = {36{1'b1}};
    localparam logic [35:0] PM  = 36'h804020100;

    logic        clock_i;
    logic        arst_n_i = 1'b0;
    logic        oe_n     = 1'b0;
    logic        flow_n   = 1'b1;
    logic        dsel     = 1'b1;
    logic        sleep    = 1'b0;
    logic        par_n    = 1'b0;
    logic        ord_n    = 1'b0;
    logic [35:0] dout;
    logic [35:0] doe;
    logic [35:0] pins;
    logic [35:0] dout_nw;
    logic [35:0] doe_nw;
    logic [5:0]  addr;
    logic [5:0]  ctl;
    logic [3:0]  be;
    logic        standby;
    int          error_cnt = 0;
    int          compares  = 0;

    sync_burst_sram_control #(.ADDR_W(6), .WIDE(1'b1)) i_sync_burst_sram_control (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr), .data_in_i(pins), .data_out_o(dout),
        .data_oe_o(doe), .chip_enable_n_i(ctl[5]), .proc_addr_strobe_n_i(ctl[4]),
        .ctrl_addr_strobe_n_i(ctl[3]), .burst_step_n_i(ctl[2]), .global_write_n_i(ctl[1]),
        .byte_write_n_i(ctl[0]), .byte_enable_n_i(be), .output_enable_n_i(oe_n),
        .flow_select_n_i(flow_n), .deselect_depth_sel_i(dsel), .sleep_req_i(sleep),
        .parity_lane_en_n_i(par_n), .burst_order_sel_n_i(ord_n), .standby_o(standby));

    // Narrow build on the same bus; only lanes a and b may answer
    sync_burst_sram_control #(.ADDR_W(6), .WIDE(1'b0)) i_sync_burst_sram_control_narrow (
        .clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr), .data_in_i(pins), .data_out_o(dout_nw),
        .data_oe_o(doe_nw), .chip_enable_n_i(ctl[5]), .proc_addr_strobe_n_i(ctl[4]),
        .ctrl_addr_strobe_n_i(ctl[3]), .burst_step_n_i(ctl[2]), .global_write_n_i(ctl[1]),
        .byte_write_n_i(ctl[0]), .byte_enable_n_i(be), .output_enable_n_i(oe_n),
        .flow_select_n_i(flow_n), .deselect_depth_sel_i(dsel), .sleep_req_i(sleep),
        .parity_lane_en_n_i(par_n), .burst_order_sel_n_i(ord_n), .standby_o());

    bus_host #(.AW(6)) i_bus_host (
        .clock_i(clock_i), .dev_out_i(dout), .dev_oe_i(doe), .pins_o(pins), .addr_o(addr),
        .ctl_o(ctl), .be_o(be));

    function automatic logic [35:0] pat(input logic [5:0] a);
        return {a, ~a, a, ~a, a, ~a};
    endfunction

    task automatic nop(input int n);
        repeat (n) i_bus_host.cmd(6'h3F, 4'hF, '0, '0);
    endtask

    task automatic dsl;
        i_bus_host.cmd(6'h37, 4'hF, '0, '0);
    endtask

    task automatic chk_rd(input string n, input logic [35:0] e);
        `CHK(n, ALL, doe)
        `CHK(n, e, dout)
        `CHK(n, 36'h0_0003_FFFF, doe_nw)
        `CHK(n, e & 36'h0_0003_FFFF, dout_nw)
    endtask

    task automatic t_rw;
        // Global write with byte inputs also active must still write every lane
        for (int a = 0; a < 8; a++) i_bus_host.cmd(6'h14, 4'h5, a[5:0], pat(a[5:0]));
        `CHK("write oe", 36'h0, doe)
        i_bus_host.cmd(6'h0C, 4'h0, 6'h05, '0);
        nop(2);
        `CHK("pipe early", 36'h0, doe)
        nop(1);
        chk_rd("pipe read", pat(6'h05));
    endtask

    task automatic t_byte;
        // Drivers must be off before the host puts write data on the pins
        repeat (2) dsl;
        i_bus_host.cmd(6'h16, 4'hA, 6'h02, ~pat(6'h02));
        i_bus_host.cmd(6'h16, 4'hF, 6'h02, '0);
        nop(3);
        chk_rd("byte write", pat(6'h02) ^ 36'h0_07FC_01FF);
    endtask

    task automatic t_burst(input logic ord);
        int         j;
        logic [1:0] lo;
        ord_n = ord;
        nop(3);
        for (int i = 0; i < 9; i++) begin
            i_bus_host.cmd(i == 0 ? 6'h13 : (i < 5 ? 6'h3B : 6'h3F), 4'hF, 6'h05, '0);
            j = i - 3;
            lo = (j >= 4) ? 2'b00 : j[1:0];
            lo = ord ? (2'b01 ^ lo) : (2'b01 + lo);
            if (j >= 0)
                `CHK("burst", pat({4'b0001, lo}), dout)
        end
    endtask

    task automatic t_desel(input logic d);
        dsel = d;
        nop(3);
        i_bus_host.cmd(6'h17, 4'hF, 6'h01, '0);
        nop(3);
        dsl;
        dsl;
        `CHK("desel N", ALL, doe)
        dsl;
        `CHK("desel N+1", d ? 36'h0 : ALL, doe)
        dsl;
        `CHK("desel N+2", 36'h0, doe)
    endtask

    task automatic t_flow_oe;
        flow_n = 1'b0;
        repeat (3) dsl;
        i_bus_host.cmd(6'h17, 4'hF, 6'h03, '0);
        nop(1);
        `CHK("flow early", 36'h0, doe)
        nop(1);
        chk_rd("flow read", pat(6'h03));
        oe_n = 1'b1;
        nop(2);
        `CHK("oe hold", ALL, doe)
        nop(1);
        `CHK("oe off", 36'h0, doe)
        oe_n = 1'b0;
        nop(3);
        `CHK("oe back", ALL, doe)
        flow_n = 1'b1;
        nop(3);
    endtask

    task automatic t_par;
        par_n = 1'b1;
        repeat (3) dsl;
        i_bus_host.cmd(6'h15, 4'hF, 6'h07, pat(6'h07));
        i_bus_host.cmd(6'h17, 4'hF, 6'h07, '0);
        nop(3);
        `CHK("parity oe", ~PM, doe)
        `CHK("parity data", pat(6'h07) & ~PM, dout)
        par_n = 1'b0;
        nop(3);
    endtask

    task automatic t_sleep;
        sleep = 1'b1;
        nop(2);
        `CHK("standby early", 1'b0, standby)
        nop(1);
        `CHK("standby", 1'b1, standby)
        i_bus_host.cmd(6'h15, 4'hF, 6'h00, ~pat(6'h00));
        nop(1);
        `CHK("sleep oe", 36'h0, doe)
        sleep = 1'b0;
        nop(3);
        i_bus_host.cmd(6'h17, 4'hF, 6'h00, '0);
        nop(3);
        chk_rd("sleep write", pat(6'h00));
    endtask

    task automatic close_out;
        $display("Comparisons %0d, errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    // Whole run is about 130 cycles
    initial begin
        repeat (3000) @(posedge clock_i);
        error_cnt++;
        close_out;
    end

    initial begin
        repeat (20) @(posedge clock_i);
        #1;
        arst_n_i = 1'b1;
        repeat (3) dsl;
        t_rw;
        t_byte;
        t_burst(1'b0);
        t_burst(1'b1);
        t_desel(1'b1);
        t_desel(1'b0);
        t_flow_oe;
        t_par;
        t_sleep;
        close_out;
    end
endmodule
